/* hdl/fssci_defs.svh */
`ifndef FSSCI_DEFS_SVH
`define FSSCI_DEFS_SVH
// Opcodes
`define FSSCI_OP_SET_WL   8'h06
`define FSSCI_OP_CLR_WL   8'h04
`define FSSCI_OP_STATUS   8'h05
`define FSSCI_OP_STWR     8'h01
`define FSSCI_OP_READ     8'h03
`define FSSCI_OP_WRITE    8'h02
`define FSSCI_OP_WIPE     8'h20
`define FSSCI_OP_FULL     8'h60
// Status bit positions
`define FSSCI_ST_BUSY     0
`define FSSCI_ST_WL       1
`define FSSCI_ST_GLO      2
`define FSSCI_ST_GHI      3
// Array geometry
`define FSSCI_WORDS       512
`define FSSCI_SECT_WORDS  256
`define FSSCI_AW          9
`define FSSCI_NARROW_TOP  8'hff
// Self-timed cycle lengths
`define FSSCI_WRITE_US    110
`define FSSCI_WIPE_MS     501
`define FSSCI_FULL_MS     1002
`define FSSCI_CLK_MHZ     10
`define FSSCI_WRITE_CYC   (`FSSCI_WRITE_US * `FSSCI_CLK_MHZ)
`define FSSCI_WIPE_CYC    (`FSSCI_WIPE_MS * 1000 * `FSSCI_CLK_MHZ)
`define FSSCI_FULL_CYC    (`FSSCI_FULL_MS * 1000 * `FSSCI_CLK_MHZ)
`endif

/* hdl/fssci_pkg.sv */
package fssci_pkg;
  // Command interpreter phases
  typedef enum logic [2:0] {
    FS_IDLE  = 3'b000,
    FS_OPC   = 3'b001,
    FS_ADDR  = 3'b010,
    FS_DATA  = 3'b011,
    FS_RDOUT = 3'b100,
    FS_STOUT = 3'b101,
    FS_WAIT  = 3'b110
  } fssci_phase_t;
  // Pending internal job
  typedef enum logic [1:0] {
    FJ_NONE  = 2'b00,
    FJ_WRITE = 2'b01,
    FJ_WIPE  = 2'b10,
    FJ_FULL  = 2'b11
  } fssci_job_t;
endpackage

/* hdl/fssci_mem.sv */
`timescale 1ns/1ps
// Flash word array with registered read, word program (AND) and sector wipe
module fssci_mem #(
  parameter int AW = 9,
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic [AW-1:0] rd_addr,   // Read address
  output logic      [DW-1:0] rd_data,   // Registered read word
  input  wire logic          wr_en,     // Program one word
  input  wire logic [AW-1:0] wr_addr,   // Program address
  input  wire logic [DW-1:0] wr_data,   // Program data
  input  wire logic [1:0]    wipe_en    // Per-sector wipe strobe
);
  logic [DW-1:0] mem [0:(1<<AW)-1];     // Storage

  // Registered read port
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

  // Program clears bits, wipe sets a whole sector to ones
  always_ff @(posedge clk) begin
    for (int i = 0; i < (1<<AW); i++) begin
      if (wipe_en[i >> (AW-1)]) begin
        mem[i] <= '1;
      end else if (wr_en && wr_addr == AW'(i)) begin
        mem[i] <= mem[i] & wr_data;
      end
    end
  end
endmodule // fssci_mem

/* hdl/fssci_buf.sv */
`timescale 1ns/1ps
// Two-entry valid/ready buffer
module fssci_buf #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,  // Word offered
  output logic              in_ready,  // Room available
  input  wire logic [W-1:0] in_data,   // Word in
  output logic              out_valid, // Word held
  input  wire logic         out_ready, // Drain accepts
  output logic      [W-1:0] out_data,  // Oldest word
  input  wire logic         flush      // Drop contents
);
  logic [W-1:0] ent_r [0:1];           // Entries
  logic [1:0]   cnt_r;                 // Fill level
  logic         rp_r;                  // Read slot
  logic         wp_r;                  // Write slot
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = ent_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Entry storage
  always_ff @(posedge clk) begin
    if (push) begin
      ent_r[wp_r] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge clk) begin
    if (!resetn || flush) begin
      cnt_r <= 2'h0;
      rp_r  <= 1'b0;
      wp_r  <= 1'b0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // fssci_buf

/* hdl/fssci_top.sv */
`timescale 1ns/1ps
`include "fssci_defs.svh"
// What this block does
// - Wide read: opcode, 16-bit address, keep nine
// - Busy cycle ignores read and write opcodes
// - Wide read streams words, wraps at end
// - Narrow read: opcode then 8-bit address
// - Narrow read stops at 255, output floats
// - Program and erase start at select rise
// - Write needs latch and unprotected address
// - Wide write: opcode, address, one word
// - Narrow write: opcode, address, one byte
// - Wide wipe: address bit 8 (the ninth) picks sector
// - Narrow wipe has no address, sector 0
// - Wipe needs latch and unprotected sector
// - Full erase needs latch, no protection
// - Write latch clear after reset
// - Only clear command drops write latch
// - Set command then wait for select rise
// - Clear command then wait for select rise
// - Read-only variant: no status, set ignored
// - Status read shifts all eight bits
// - While busy only status read; bits frozen
// - Self-timed cycles reported by busy flag
// - Status: busy, latch, two guard bits
// - Sample rising, drive falling, MSB first
// - Bad opcode ignored until select rises
// - Narrow 8-bit sector 0, wide 16-bit both
module fssci_top #(
  parameter bit          WIDE      = 1'b1,               // Wide or narrow mode
  parameter bit          READ_ONLY = 1'b0,               // Read-only variant
  parameter int unsigned WRITE_CYC = `FSSCI_WRITE_CYC,   // Word program length
  parameter int unsigned WIPE_CYC  = `FSSCI_WIPE_CYC,    // Sector wipe length
  parameter int unsigned FULL_CYC  = `FSSCI_FULL_CYC     // Full erase length
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic chip_select_n,   // SPI select, active low
  input  wire logic sck,             // SPI clock
  input  wire logic si,              // SPI data in
  output logic      so_out,          // SPI data out level
  output logic      so_oe_n,         // Low while driving data out
  input  wire logic guard_level_hi,  // Protection level high bit
  input  wire logic guard_level_lo,  // Protection level low bit
  output logic      busy_flag        // Internal cycle running
);
  import fssci_pkg::*;

  localparam int DW = WIDE ? 16 : 8;      // Field width of address and data
  localparam int AW = `FSSCI_AW;

  // Input synchronisers
  logic [1:0] cs_s, ck_s, si_s;
  logic       ck_d;
  logic       sel, rise, fall, cs_d;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cs_s <= 2'b11;
      ck_s <= 2'b00;
      si_s <= 2'b00;
      ck_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      cs_s <= {cs_s[0], chip_select_n};
      ck_s <= {ck_s[0], sck};
      si_s <= {si_s[0], si};
      ck_d <= ck_s[1];
      cs_d <= cs_s[1];
    end
  end
  assign sel  = !cs_s[1];
  assign rise = sel && ck_s[1] && !ck_d;
  assign fall = sel && !ck_s[1] && ck_d;
  logic cs_up;
  assign cs_up = cs_s[1] && !cs_d;

  // Interpreter state
  fssci_phase_t ph_r;
  logic [4:0]   bit_r;                 // Bits in current field
  logic [15:0]  sh_r;                  // Input shift register
  logic [7:0]   op_r;                  // Accepted opcode
  logic [AW-1:0] addr_r;               // Target address
  logic [15:0]  wdat_r;                // Write word
  fssci_job_t   job_r;                 // Armed job at select rise
  fssci_job_t   run_r;                 // Running job
  logic [23:0]  tmr_r;                 // Cycle timer
  logic         wl_r;                  // Write latch
  logic [1:0]   glv_r;                 // Guard level, frozen while busy
  logic [15:0]  osh_r;                 // Output shift register
  logic [4:0]   obit_r;                // Bits left to shift out
  logic         so_r, oe_r;
  logic         stop_r;                // Narrow read reached its end
  logic [1:0]   wipe;
  logic         prog;

  // Protection checks
  logic guard_all, guard_none;
  assign guard_none = (glv_r == 2'b00);
  assign guard_all  = (glv_r == 2'b11);
  logic [7:0] status;
  assign status = {4'h0, glv_r[1], glv_r[0], wl_r, busy_flag};

  // Read path: memory then two-entry buffer to output shifter
  logic [AW-1:0] rd_a;
  logic [15:0]   rd_d;
  logic          bi_v, bi_rdy, bo_v, bo_rdy, flush;
  logic [15:0]   bo_d;
  logic          fetch_r, fvld_r;
  logic [AW-1:0] next_a;
  assign rd_a   = addr_r;
  assign next_a = WIDE ? addr_r + 1'b1 : {1'b0, addr_r[7:0] + 8'h01};
  assign bi_v   = fvld_r;
  assign flush  = !sel;

  fssci_mem #(.AW(AW), .DW(16)) u_mem (
    .clk     (clk),
    .rd_addr (rd_a),
    .rd_data (rd_d),
    .wr_en   (prog),
    .wr_addr (addr_r),
    .wr_data (wdat_r),
    .wipe_en (wipe)
  );

  fssci_buf #(.W(16)) u_buf (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (bi_v),
    .in_ready  (bi_rdy),
    .in_data   (rd_d),
    .out_valid (bo_v),
    .out_ready (bo_rdy),
    .out_data  (bo_d),
    .flush     (flush)
  );

  // Fetcher: one word in flight, stalls when buffer full
  always_ff @(posedge clk) begin
    if (!resetn || !sel || ph_r != FS_RDOUT) begin
      fetch_r <= 1'b0;
      fvld_r  <= 1'b0;
    end else begin
      fvld_r  <= fetch_r;
      fetch_r <= !fetch_r && !fvld_r && bi_rdy && !stop_r;
    end
  end

  // Command decode and field capture
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ph_r   <= FS_IDLE;
      bit_r  <= 5'h0;
      sh_r   <= 16'h0;
      op_r   <= 8'h0;
      addr_r <= '0;
      wdat_r <= 16'hffff;
      job_r  <= FJ_NONE;
      stop_r <= 1'b0;
    end else if (!sel) begin
      ph_r   <= FS_OPC;
      bit_r  <= 5'h0;
      stop_r <= 1'b0;
      if (cs_up) begin
        job_r <= FJ_NONE;
      end
    end else begin
      if (fvld_r) begin
        if (!WIDE && addr_r[7:0] == `FSSCI_NARROW_TOP) begin
          stop_r <= 1'b1;
        end else begin
          addr_r <= next_a;
        end
      end
      if (rise) begin
        sh_r  <= {sh_r[14:0], si_s[1]};
        bit_r <= bit_r + 5'h1;
        unique case (ph_r)
          FS_OPC: if (bit_r == 5'd7) begin
            bit_r <= 5'h0;
            op_r  <= {sh_r[6:0], si_s[1]};
            unique case ({sh_r[6:0], si_s[1]})
              `FSSCI_OP_READ, `FSSCI_OP_WRITE:
                ph_r <= busy_flag ? FS_WAIT : FS_ADDR;
              `FSSCI_OP_STATUS:
                ph_r <= READ_ONLY ? FS_WAIT : FS_STOUT;
              `FSSCI_OP_WIPE: begin
                if (busy_flag || READ_ONLY) begin
                  ph_r <= FS_WAIT;
                end else if (WIDE) begin
                  ph_r <= FS_ADDR;
                end else begin
                  ph_r   <= FS_WAIT;
                  addr_r <= '0;
                  job_r  <= (wl_r && !guard_all) ? FJ_WIPE : FJ_NONE;
                end
              end
              `FSSCI_OP_FULL: begin
                ph_r  <= FS_WAIT;
                job_r <= (!busy_flag && !READ_ONLY && wl_r && guard_none) ?
                         FJ_FULL : FJ_NONE;
              end
              default: ph_r <= FS_WAIT;
            endcase
          end
          FS_ADDR: if (bit_r == 5'(DW-1)) begin
            bit_r <= 5'h0;
            addr_r <= WIDE ? AW'({sh_r[14:0], si_s[1]}) :
                      {1'b0, sh_r[6:0], si_s[1]};
            if (op_r == `FSSCI_OP_READ) begin
              ph_r <= FS_RDOUT;
            end else if (op_r == `FSSCI_OP_WIPE) begin
              ph_r  <= FS_WAIT;
              job_r <= (wl_r && !guard_all) ? FJ_WIPE : FJ_NONE;
            end else begin
              ph_r <= (wl_r && !guard_all) ? FS_DATA : FS_WAIT;
            end
          end
          FS_DATA: if (bit_r == 5'(DW-1)) begin
            ph_r   <= FS_WAIT;
            wdat_r <= WIDE ? {sh_r[14:0], si_s[1]} : {8'hff, sh_r[6:0], si_s[1]};
            job_r  <= FJ_WRITE;
          end else if (bit_r > 5'(DW-1)) begin
            job_r <= FJ_NONE;
          end
          FS_WAIT: if (job_r == FJ_WRITE || job_r == FJ_WIPE || job_r == FJ_FULL) begin
            if (op_r == `FSSCI_OP_WRITE) begin
              job_r <= FJ_NONE;                          // Extra data cancels write
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Write latch
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wl_r <= 1'b0;
    end else if (rise && ph_r == FS_OPC && bit_r == 5'd7 && !busy_flag && !READ_ONLY) begin
      if ({sh_r[6:0], si_s[1]} == `FSSCI_OP_SET_WL) begin
        wl_r <= 1'b1;
      end else if ({sh_r[6:0], si_s[1]} == `FSSCI_OP_CLR_WL) begin
        wl_r <= 1'b0;
      end
    end
  end

  // Opcode as completed on this rise, and the clear-latch hit
  logic [7:0] opc_in;
  logic       clr_hit;
  assign opc_in  = {sh_r[6:0], si_s[1]};
  assign clr_hit = rise && ph_r == FS_OPC && bit_r == 5'd7 && !busy_flag && !READ_ONLY &&
                   opc_in == `FSSCI_OP_CLR_WL;

  // Latch is clear right after any reset edge
  latch_reset_a: assert property (@(posedge clk) !resetn |=> !wl_r)
    else $error("write latch set after reset");

  // Latch drops only through the clear command
  latch_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(wl_r) |-> $past(clr_hit))
    else $error("write latch dropped without clear command");

  // Any armed job was armed with the latch set
  job_latch_a: assert property (@(posedge clk) disable iff (!resetn)
    (job_r != FJ_NONE) |-> wl_r)
    else $error("job armed with write latch clear");

  // Read or write opcode while busy goes to the wait phase
  busy_refuse_a: assert property (@(posedge clk) disable iff (!resetn)
    (rise && ph_r == FS_OPC && bit_r == 5'd7 && busy_flag &&
     (opc_in == `FSSCI_OP_READ || opc_in == `FSSCI_OP_WRITE)) |=> (ph_r == FS_WAIT))
    else $error("read or write accepted while busy");

  // Guard level is guarded per busy cycle
  // Guard level follows pins except during an internal cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      glv_r <= 2'b00;
    end else if (!busy_flag) begin
      glv_r <= {guard_level_hi, guard_level_lo};
    end
  end

  // Self-timed cycle launched at select rise
  always_ff @(posedge clk) begin
    if (!resetn) begin
      run_r <= FJ_NONE;
      tmr_r <= 24'h0;
    end else if (run_r != FJ_NONE) begin
      if (tmr_r == 24'h1) begin
        run_r <= FJ_NONE;
      end
      tmr_r <= tmr_r - 24'h1;
    end else if (cs_up && job_r != FJ_NONE) begin
      run_r <= job_r;
      unique case (job_r)
        FJ_WRITE: tmr_r <= 24'(WRITE_CYC);
        FJ_WIPE:  tmr_r <= 24'(WIPE_CYC);
        default:  tmr_r <= 24'(FULL_CYC);
      endcase
    end
  end
  assign busy_flag = (run_r != FJ_NONE);

  // Launch at select rise, then a run of busy cycles
  sequence launch_s;
    cs_up && job_r != FJ_NONE && !busy_flag;
  endsequence
  sequence busy_run_s;
    busy_flag [*8];
  endsequence
  busy_run_a: assert property (@(posedge clk) disable iff (!resetn)
    launch_s |=> busy_run_s)
    else $error("busy cycle did not follow select rise");

  // Guard level status bits stay frozen while busy
  guard_frozen_a: assert property (@(posedge clk) disable iff (!resetn)
    busy_flag |=> $stable(glv_r))
    else $error("guard level changed while busy");
  assign prog = (run_r == FJ_WRITE) && (tmr_r == 24'h1);
  assign wipe[0] = (tmr_r == 24'h1) && ((run_r == FJ_FULL) ||
                   (run_r == FJ_WIPE && !addr_r[AW-1]));
  assign wipe[1] = (tmr_r == 24'h1) && WIDE && ((run_r == FJ_FULL) ||
                   (run_r == FJ_WIPE && addr_r[AW-1]));

  // Output shifter: status or read words, MSB first on falling edges
  assign bo_rdy = (ph_r == FS_RDOUT) && fall && (obit_r == 5'h0);
  always_ff @(posedge clk) begin
    if (!resetn || !sel) begin
      osh_r  <= 16'h0;
      obit_r <= 5'h0;
      so_r   <= 1'b0;
      oe_r   <= 1'b0;
    end else if (fall) begin
      if (obit_r != 5'h0) begin
        so_r   <= osh_r[15];
        osh_r  <= {osh_r[14:0], 1'b0};
        obit_r <= obit_r - 5'h1;
      end else if (ph_r == FS_STOUT) begin
        so_r   <= status[7];
        osh_r  <= {status[6:0], 9'h0};
        obit_r <= 5'd7;
        oe_r   <= 1'b1;
      end else if (ph_r == FS_RDOUT && bo_v) begin
        so_r   <= WIDE ? bo_d[15] : bo_d[7];
        osh_r  <= WIDE ? {bo_d[14:0], 1'b0} : {bo_d[6:0], 9'h0};
        obit_r <= 5'(DW-1);
        oe_r   <= 1'b1;
      end else begin
        oe_r <= 1'b0;
      end
    end
  end
  // Data out is only switched on in an output phase
  drive_phase_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(oe_r) |-> (ph_r == FS_STOUT || ph_r == FS_RDOUT))
    else $error("data out driven outside an output phase");
  assign so_out  = so_r;
  assign so_oe_n = !oe_r;
endmodule // fssci_top

/* tb/fssci_spi_master.sv */
`timescale 1ns/1ps
// Behavioural SPI master facing the three device instances
module fssci_spi_master (
  input  wire logic       clk,
  output logic      [2:0] chip_select_n, // One select per instance
  output logic            sck,           // Serial clock, low between frames
  output logic            si,            // Serial data towards the devices
  input  wire logic       so_line        // Resolved data out, x while floating
);
  // Idle bus: nobody selected, clock parked low
  initial begin
    chip_select_n = 3'h7;
    sck = 1'b0;
    si = 1'b0;
  end

  // One whole frame, nbits shifted MSB first, data out caught before each fall
  task automatic frame(input int sel, input int nbits, input logic [63:0] tx,
                       output logic [63:0] rx);
    rx = '0;
    @(posedge clk);
    #5 chip_select_n[sel] = 1'b0;
    // Select to first rising edge well over the setup time
    repeat (8) @(posedge clk);
    for (int i = nbits - 1; i >= 0; i--) begin
      // Data changes while the clock is low, device samples at the rise
      @(posedge clk);
      #5 si = tx[i];
      repeat (4) @(posedge clk);
      #5 sck = 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rx[i] = so_line;
      @(posedge clk);
      #5 sck = 1'b0;
    end
    // Released data line shows the inverse of its last level
    repeat (4) @(posedge clk);
    #5 si = ~si;
    // Rising select ends the frame and triggers any pending job
    chip_select_n[sel] = 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule // fssci_spi_master

/* tb/tb.sv */
`timescale 1ns/1ps
// Bench: wide, narrow and read-only instances on one shared SPI bus
module tb;
  logic        clk;        // System clock
  logic        resetn;     // Synchronous reset, active low
  logic        gh;         // Guard level high pin
  logic        gl;         // Guard level low pin
  logic        sck;        // Serial clock from the master
  logic        si;         // Serial data from the master
  logic        so_line;    // Resolved serial data out
  logic [2:0]  cs_n;       // Per-instance selects
  logic [2:0]  so;         // Data out levels
  logic [2:0]  oe_n;       // Data out enables, low while driving
  logic [2:0]  busy;       // Busy flags
  logic [63:0] rx;         // Bits caught in the last frame
  int          n_mismatch; // Mismatches seen
  int          checked;    // Comparisons made

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Instance 0 wide, 1 narrow, 2 wide read-only; cycles shortened
  for (genvar g = 0; g < 3; g++) begin : g_dev
    fssci_top #(.WIDE(g != 1), .READ_ONLY(g == 2), .WRITE_CYC(20),
                .WIPE_CYC(40), .FULL_CYC(1000)) DUT (
      .clk(clk), .resetn(resetn), .chip_select_n(cs_n[g]), .sck(sck),
      .si(si), .so_out(so[g]), .so_oe_n(oe_n[g]), .guard_level_hi(gh),
      .guard_level_lo(gl), .busy_flag(busy[g]));
  end

  // Floating data line reads as unknown
  assign so_line = !oe_n[0] ? so[0] : !oe_n[1] ? so[1] : !oe_n[2] ? so[2] : 1'bx;

  fssci_spi_master spi_m (.clk(clk), .chip_select_n(cs_n), .sck(sck), .si(si),
                          .so_line(so_line));

  // Compare and count
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input int sel, input int nbits, input logic [63:0] tx);
    spi_m.frame(sel, nbits, tx, rx);
  endtask

  // Status read: opcode then eight bits out
  task automatic status(input int sel, input logic [7:0] exp);
    spi_m.frame(sel, 16, {8'h05, 8'h00}, rx);
    check("status", exp, rx[7:0]);
  endtask

  // Busy level shortly after the select rise
  task automatic busy_is(input int sel, input logic exp);
    repeat (10) @(posedge clk);
    @(negedge clk);
    check("busy", exp, busy[sel]);
  endtask

  // Bounded wait for the self-timed cycle to end
  task automatic idle(input int sel);
    for (int i = 0; i < 1500 && busy[sel] !== 1'b0; i++) @(negedge clk);
    check("idle", 1'b0, busy[sel]);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("unexpected timeout: expected done seen hang");
    end_of_test();
  end

  // Main sequence; only erased locations are ever written
  initial begin
    resetn = 1'b0;
    gh = 1'b0;
    gl = 1'b0;
    n_mismatch = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    #5 resetn = 1'b1;
    repeat (3) @(posedge clk);
    status(0, 8'h00);
    xfer(0, 40, {8'h02, 16'h0005, 16'h0000});
    busy_is(0, 1'b0);
    xfer(0, 16, {8'h06, 8'hff});
    status(0, 8'h02);
    xfer(0, 8, 8'h60);
    busy_is(0, 1'b1);
    xfer(0, 40, {8'h03, 16'h0000, 16'h0000});
    check("read while busy", 16'hxxxx, rx[15:0]);
    status(0, 8'h03);
    idle(0);
    xfer(0, 40, {8'h02, 16'hffff, 16'h1234});
    busy_is(0, 1'b1);
    idle(0);
    xfer(0, 40, {8'h02, 16'hfe00, 16'habcd});
    idle(0);
    xfer(0, 56, {8'h03, 16'h01ff, 32'h0});
    check("wrap read", 32'h1234abcd, rx[31:0]);
    status(0, 8'h02);
    @(posedge clk);
    #5 gh = 1'b1;
    gl = 1'b1;
    status(0, 8'h0e);
    xfer(0, 40, {8'h02, 16'h0010, 16'h0000});
    busy_is(0, 1'b0);
    xfer(0, 24, {8'h20, 16'h0100});
    busy_is(0, 1'b0);
    xfer(0, 8, 8'h60);
    busy_is(0, 1'b0);
    @(posedge clk);
    #5 gh = 1'b0;
    gl = 1'b0;
    xfer(0, 24, {8'h20, 16'h0100});
    busy_is(0, 1'b1);
    idle(0);
    xfer(0, 56, {8'h03, 16'h01ff, 32'h0});
    check("sector wipe", 32'hffffabcd, rx[31:0]);
    xfer(0, 8, 8'h04);
    status(0, 8'h00);
    xfer(0, 40, {8'h02, 16'h0020, 16'h0000});
    busy_is(0, 1'b0);
    xfer(0, 24, {8'haa, 16'h0500});
    check("bad opcode", 16'hxxxx, rx[15:0]);
    xfer(1, 8, 8'h06);
    xfer(1, 8, 8'h60);
    busy_is(1, 1'b1);
    idle(1);
    xfer(1, 24, {8'h02, 8'hfe, 8'h5a});
    busy_is(1, 1'b1);
    idle(1);
    xfer(1, 40, {8'h03, 8'hfe, 24'h0});
    check("narrow read", 24'h5affxx, rx[23:0]);
    xfer(1, 8, 8'h20);
    busy_is(1, 1'b1);
    idle(1);
    xfer(1, 24, {8'h03, 8'hfe, 8'h00});
    check("narrow wipe", 8'hff, rx[7:0]);
    xfer(2, 8, 8'h06);
    status(2, 8'hxx);
    end_of_test();
  end
endmodule // tb
